/* File: dv/por_cfg_checker.sv */
// Concurrent checks on the link between reset host and sequencing device
`timescale 1ns/1ps
module por_cfg_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic power_on_reset_in,
  input wire logic reset_config_select,
  input wire logic cfg_wr_strobe,
  input wire logic hard_reset_out,
  input wire logic soft_reset_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Repeat counts assume the bench's short sequence lengths
  a_soft_lag_three: assert property (
    $fell(hard_reset_out) |-> soft_reset_out[*3] ##1 !soft_reset_out)
    else $error("soft reset did not trail hard reset by three clocks");
  a_soft_not_first: assert property (
    !soft_reset_out |-> !hard_reset_out)
    else $error("soft reset released before hard reset");
  a_por_resets_all: assert property (
    !power_on_reset_in |=> hard_reset_out && soft_reset_out)
    else $error("resets not asserted while reset input low");
  a_por_rise_holds: assert property (
    $rose(power_on_reset_in) |-> hard_reset_out[*8])
    else $error("hard reset released during configuration");
  a_bytes_keep_hard: assert property (
    $fell(cfg_wr_strobe) |-> hard_reset_out[*8])
    else $error("hard reset released too soon after the word");
  a_strobe_after_por: assert property (
    cfg_wr_strobe |-> power_on_reset_in && $past(power_on_reset_in))
    else $error("byte written before reset input rose");
  a_burst_of_four: assert property (
    $rose(cfg_wr_strobe) |-> cfg_wr_strobe[*4] ##1 !cfg_wr_strobe)
    else $error("word not sent as four bytes");
  a_select_held_high: assert property (
    cfg_wr_strobe |-> reset_config_select)
    else $error("config select low during host configuration");
endmodule : por_cfg_checker

/* File: dv/power_on_reset_config_sequencer_test.sv */
// Self-checking bench joining host and device ends of the reset link
`timescale 1ns/1ps
`include "por_cfg_regs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  miscompares++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module power_on_reset_config_sequencer_test;
  localparam int CFG_N = 4;
  localparam int PLL_N = 4;
  localparam int DLL_N = 4;
  localparam int HARD_N = 4;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic por = 1'b0;
  logic host_strap = 1'b0;
  logic [2:0] straps = 3'h0;
  logic [31:0] hw_word = 32'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [31:0] rdata;
  logic host_mode, config_slave, clocks_enabled, dll_locked;
  logic internal_reset;
  logic [31:0] config_word;
  logic [2:0] clock_mode_sampled;
  logic [6:0] pll_setting;
  int miscompares = 0;
  int check_count = 0;

  // Clock at 25 MHz
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  por_cfg_if i_por_cfg_if (.power_on_reset_in(por));
  por_cfg_device #(.CONFIG_CYCLES(CFG_N), .PLL_LOCK_CYCLES(PLL_N),
    .DLL_LOCK_CYCLES(DLL_N), .HARD_HOLD_CYCLES(HARD_N),
    .SOFT_LAG_CYCLES(3)) i_por_cfg_device (
    .core_clk(core_clk), .rst_b(rst_b), .link(i_por_cfg_if),
    .host_port_enable_strap(host_strap), .clock_mode_straps(straps),
    .hw_config_word(hw_word), .host_mode(host_mode),
    .config_slave(config_slave), .config_word(config_word),
    .clock_mode_sampled(clock_mode_sampled), .pll_setting(pll_setting),
    .clocks_enabled(clocks_enabled), .dll_locked(dll_locked),
    .internal_reset(internal_reset));
  por_cfg_host i_por_cfg_host (.core_clk(core_clk), .rst_b(rst_b),
    .link(i_por_cfg_if), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata));
  por_cfg_checker i_por_cfg_checker (.core_clk(core_clk), .rst_b(rst_b),
    .power_on_reset_in(i_por_cfg_if.power_on_reset_in),
    .reset_config_select(i_por_cfg_if.reset_config_select),
    .cfg_wr_strobe(i_por_cfg_if.cfg_wr_strobe),
    .hard_reset_out(i_por_cfg_if.hard_reset_out),
    .soft_reset_out(i_por_cfg_if.soft_reset_out));

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge core_clk);
    wr_strobe <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge core_clk);
    rd_strobe <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask : rd

  // Drop the reset input so the device starts its sequence over
  task automatic por_low();
    @(posedge core_clk);
    por <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : por_low

  // One full sequence: straps, rise, lock, hard then soft release
  task automatic run(input logic host, input logic [31:0] word,
                     input logic [2:0] ms, input logic slave);
    int n;
    @(posedge core_clk);
    host_strap <= host;
    straps <= ms;
    hw_word <= word;
    step();
    `CHK(i_por_cfg_if.hard_reset_out, 1'b1)
    `CHK(i_por_cfg_if.soft_reset_out, 1'b1)
    @(posedge core_clk);
    por <= 1'b1;
    #1;
    `CHK(internal_reset, 1'b1)
    if (host) begin
      n = 0;
      while (internal_reset === 1'b1 && n < 50) begin
        step();
        n++;
      end
      `CHK(config_word, word)
    end
    n = 0;
    while (clocks_enabled !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    // Hardware mode counts from the rise, one edge before config starts
    `CHK(n, CFG_N + PLL_N + int'(!host))
    `CHK(host_mode, host)
    `CHK(config_slave, slave)
    `CHK(clock_mode_sampled, ms)
    `CHK(pll_setting, {word[27:24], ms})
    `CHK(i_por_cfg_if.hard_reset_out, 1'b1)
    n = 0;
    while (i_por_cfg_if.hard_reset_out === 1'b1 && n < 100) begin
      step();
      n++;
    end
    `CHK(n, HARD_N + (word[28] ? 0 : DLL_N))
    `CHK(dll_locked, ~word[28])
    n = 0;
    while (i_por_cfg_if.soft_reset_out === 1'b1 && n < 20) begin
      step();
      n++;
    end
    `CHK(n, 3)
  endtask : run

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(`HOST_REG_STATUS, 32'h0000_000c);
    rd(`HOST_REG_CTRL, `HOST_CTRL_RESET);
    wr(`HOST_REG_WORD, 32'h1234_5678);
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc, 32'h0);
    rd(`HOST_REG_WORD, 32'h1234_5678);
    run(1'b0, 32'h1a00_0000, 3'h5, 1'b1);
    wr(`HOST_REG_CTRL, 32'h0);
    por_low();
    run(1'b0, 32'h0300_0000, 3'h2, 1'b0);
    por_low();
    wr(`HOST_REG_WORD, 32'h1c5a_3cf0);
    wr(`HOST_REG_CTRL, 32'h3);
    run(1'b1, 32'h1c5a_3cf0, 3'h6, 1'b1);
    rd(`HOST_REG_STATUS, 32'h0000_0012);
    tally_and_finish();
  end
endmodule : power_on_reset_config_sequencer_test

/* File: rtl/por_cfg_device.sv */
// Power-on reset configuration sequencer, device end
//
// Overview of operation
// - Strap high at reset rise selects host mode
// - Host holds config select high in host mode; the host drives select from its control register bit, whatever the mode
// - Hold internal reset until host word written
// - Host sends word as four byte writes
// - Host writes only after reset input rises
// - Host runs on core_clk, the same clock as the device
// - Hard release 512 clocks after lock, soft +3
// - Strap low at reset rise selects hardware mode
// - Select high means slave, low means master
// - Both resets asserted through config and locking
// - Config lasts 1024 clocks, then sample mode straps
// - PLL setting uses straps and high field
// - PLL lock wait is 800 reference clocks
// - Enable all clocks once PLL locks
// - DLL lock follows PLL unless bypass bit set
`timescale 1ns/1ps
`include "por_cfg_regs.svh"
module por_cfg_device #(
  parameter int CONFIG_CYCLES = `CFG_CONFIG_CYCLES,
  parameter int PLL_LOCK_CYCLES = `CFG_PLL_LOCK_CYCLES,
  parameter int DLL_LOCK_CYCLES = `CFG_DLL_LOCK_CYCLES,
  parameter int HARD_HOLD_CYCLES = `CFG_HARD_HOLD_CYCLES,
  parameter int SOFT_LAG_CYCLES = `CFG_SOFT_LAG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  por_cfg_if.device link,
  input wire logic host_port_enable_strap,
  input wire logic [2:0] clock_mode_straps,
  input wire logic [31:0] hw_config_word,
  output logic host_mode,
  output logic config_slave,
  output logic [31:0] config_word,
  output logic [2:0] clock_mode_sampled,
  output logic [`CFG_CLK_HIGH_W+2:0] pll_setting,
  output logic clocks_enabled,
  output logic dll_locked,
  output logic internal_reset
);

  localparam int CW = `CFG_CNT_W;

  por_cfg_pkg::seq_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic por_q;
  logic [1:0] byte_cnt_q, byte_cnt_d;
  logic [31:0] word_q, word_d;
  logic host_mode_q, host_mode_d;
  logic slave_q, slave_d;
  logic [2:0] mode_straps_q, mode_straps_d;
  logic clk_en_q, clk_en_d;
  logic dll_lock_q, dll_lock_d;
  logic hard_q, hard_d;
  logic soft_q, soft_d;
  logic int_rst_q, int_rst_d;

  // Terminal count test, shared by every timed phase
  function automatic logic cnt_at(input logic [CW-1:0] c, input int n);
    cnt_at = (c == CW'(n - 1));
  endfunction : cnt_at

  // Reset input events; input is taken as synchronous to core_clk
  wire por_rise = link.power_on_reset_in & ~por_q;
  wire por_low = ~link.power_on_reset_in;

  // Phase end decodes
  wire config_end = cnt_at(cnt_q, CONFIG_CYCLES);
  wire pll_end = cnt_at(cnt_q, PLL_LOCK_CYCLES);
  wire dll_end = cnt_at(cnt_q, DLL_LOCK_CYCLES);
  wire hard_end = cnt_at(cnt_q, HARD_HOLD_CYCLES);
  wire soft_end = cnt_at(cnt_q, SOFT_LAG_CYCLES);

  // Configuration word fields
  wire dll_bypass_bit = word_q[`CFG_DLL_BYPASS_BIT];
  wire [`CFG_CLK_HIGH_W-1:0] clock_mode_high_field =
    word_q[`CFG_CLK_HIGH_LSB +: `CFG_CLK_HIGH_W];

  // Host byte accepted only while the word is being built
  wire host_byte = (state_q == por_cfg_pkg::SEQ_HOST_CFG) &
    link.cfg_wr_strobe;
  wire last_byte = host_byte &
    (byte_cnt_q == 2'(`CFG_WORD_BYTES - 1));
  wire [31:0] word_shifted = {word_q[23:0], link.cfg_wr_data};

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + CW'(1);
    byte_cnt_d = byte_cnt_q;
    word_d = word_q;
    host_mode_d = host_mode_q;
    slave_d = slave_q;
    mode_straps_d = mode_straps_q;
    clk_en_d = clk_en_q;
    dll_lock_d = dll_lock_q;
    hard_d = hard_q;
    soft_d = soft_q;
    int_rst_d = int_rst_q;
    if (por_low) begin
      // Reset input low restarts the whole sequence from any phase
      state_d = por_cfg_pkg::SEQ_POR;
      cnt_d = '0;
      byte_cnt_d = '0;
      clk_en_d = 1'b0;
      dll_lock_d = 1'b0;
      hard_d = 1'b1;
      soft_d = 1'b1;
      int_rst_d = 1'b1;
    end else begin
      unique case (state_q)
        por_cfg_pkg::SEQ_POR: begin
          cnt_d = '0;
          if (por_rise) begin
            host_mode_d = host_port_enable_strap;
            slave_d = link.reset_config_select;
            if (host_port_enable_strap) begin
              state_d = por_cfg_pkg::SEQ_HOST_CFG;
            end else begin
              word_d = hw_config_word;
              int_rst_d = 1'b0;
              state_d = por_cfg_pkg::SEQ_CONFIG;
            end
          end
        end
        por_cfg_pkg::SEQ_HOST_CFG: begin
          // Internal reset stays on until the fourth byte lands
          cnt_d = '0;
          if (host_byte) begin
            word_d = word_shifted;
            byte_cnt_d = byte_cnt_q + 2'd1;
          end
          if (last_byte) begin
            int_rst_d = 1'b0;
            state_d = por_cfg_pkg::SEQ_CONFIG;
          end
        end
        por_cfg_pkg::SEQ_CONFIG: begin
          if (config_end) begin
            mode_straps_d = clock_mode_straps;
            cnt_d = '0;
            state_d = por_cfg_pkg::SEQ_PLL_LOCK;
          end
        end
        por_cfg_pkg::SEQ_PLL_LOCK: begin
          if (pll_end) begin
            clk_en_d = 1'b1;
            cnt_d = '0;
            if (dll_bypass_bit) begin
              state_d = por_cfg_pkg::SEQ_HARD_HOLD;
            end else begin
              state_d = por_cfg_pkg::SEQ_DLL_LOCK;
            end
          end
        end
        por_cfg_pkg::SEQ_DLL_LOCK: begin
          if (dll_end) begin
            dll_lock_d = 1'b1;
            cnt_d = '0;
            state_d = por_cfg_pkg::SEQ_HARD_HOLD;
          end
        end
        por_cfg_pkg::SEQ_HARD_HOLD: begin
          if (hard_end) begin
            hard_d = 1'b0;
            cnt_d = '0;
            state_d = por_cfg_pkg::SEQ_SOFT_LAG;
          end
        end
        por_cfg_pkg::SEQ_SOFT_LAG: begin
          if (soft_end) begin
            soft_d = 1'b0;
            state_d = por_cfg_pkg::SEQ_RUN;
          end
        end
        por_cfg_pkg::SEQ_RUN: begin
          cnt_d = cnt_q;
        end
      endcase
    end
  end

  // Sequencer state; asserted resets are the safe reset value
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= por_cfg_pkg::SEQ_POR;
      cnt_q <= '0;
      por_q <= 1'b0;
      byte_cnt_q <= '0;
      word_q <= `CFG_WORD_RESET;
      host_mode_q <= 1'b0;
      slave_q <= 1'b0;
      mode_straps_q <= '0;
      clk_en_q <= 1'b0;
      dll_lock_q <= 1'b0;
      hard_q <= 1'b1;
      soft_q <= 1'b1;
      int_rst_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      por_q <= link.power_on_reset_in;
      byte_cnt_q <= byte_cnt_d;
      word_q <= word_d;
      host_mode_q <= host_mode_d;
      slave_q <= slave_d;
      mode_straps_q <= mode_straps_d;
      clk_en_q <= clk_en_d;
      dll_lock_q <= dll_lock_d;
      hard_q <= hard_d;
      soft_q <= soft_d;
      int_rst_q <= int_rst_d;
    end
  end

  // Outputs straight from flops
  assign link.hard_reset_out = hard_q;
  assign link.soft_reset_out = soft_q;
  assign host_mode = host_mode_q;
  assign config_slave = slave_q;
  assign config_word = word_q;
  assign clock_mode_sampled = mode_straps_q;
  // PLL ratio: sampled straps below the high field of the word
  assign pll_setting = {clock_mode_high_field, mode_straps_q};
  assign clocks_enabled = clk_en_q;
  assign dll_locked = dll_lock_q;
  assign internal_reset = int_rst_q;

endmodule : por_cfg_device

/* File: rtl/por_cfg_host.sv */
// Host end: programs the reset configuration word over the link
`timescale 1ns/1ps
`include "por_cfg_regs.svh"
module por_cfg_host (
  input wire logic core_clk,
  input wire logic rst_b,
  por_cfg_if.host link,
  input wire logic [`HOST_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rdata
);

  // Whole control reset word, so one bit can be picked out by position
  localparam logic [31:0] CTRL_RESET = `HOST_CTRL_RESET;

  por_cfg_pkg::host_state_t state_q, state_d;
  logic [31:0] word_q;
  logic [31:0] shift_q, shift_d;
  logic [1:0] sent_q, sent_d;
  logic select_q;
  logic done_q, done_d;
  logic por_q;
  logic strobe_q, strobe_d;
  logic [7:0] data_q, data_d;
  logic [31:0] rdata_q;

  // Register decode
  wire wr_word = wr_strobe & (addr == `HOST_REG_WORD);
  wire wr_ctrl = wr_strobe & (addr == `HOST_REG_CTRL);
  wire go = wr_ctrl & wdata[`HOST_CTRL_GO_BIT];
  wire busy = (state_q != por_cfg_pkg::HOST_IDLE) &
    (state_q != por_cfg_pkg::HOST_DONE);

  // Status view of the link and of the transfer
  wire [31:0] status = {27'h0, link.power_on_reset_in,
    link.soft_reset_out, link.hard_reset_out, done_q, busy};
  wire [31:0] ctrl_view = {30'h0, select_q, 1'b0};
  wire [31:0] rd_mux = (addr == `HOST_REG_WORD) ? word_q :
    (addr == `HOST_REG_CTRL) ? ctrl_view :
    (addr == `HOST_REG_STATUS) ? status : 32'h0000_0000;

  // Reset input has been high for a full cycle, so the device listens
  wire por_settled = link.power_on_reset_in & por_q;

  // Transfer engine: most significant byte goes first
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    sent_d = sent_q;
    done_d = done_q;
    strobe_d = 1'b0;
    data_d = data_q;
    unique case (state_q)
      por_cfg_pkg::HOST_IDLE, por_cfg_pkg::HOST_DONE: begin
        if (go) begin
          shift_d = word_q;
          sent_d = '0;
          done_d = 1'b0;
          state_d = por_cfg_pkg::HOST_WAIT_POR;
        end
      end
      por_cfg_pkg::HOST_WAIT_POR: begin
        if (por_settled) begin
          state_d = por_cfg_pkg::HOST_SEND;
        end
      end
      por_cfg_pkg::HOST_SEND: begin
        if (!link.power_on_reset_in) begin
          // Reset fell mid-word: start the word over after next rise
          shift_d = word_q;
          sent_d = '0;
          state_d = por_cfg_pkg::HOST_WAIT_POR;
        end else begin
          strobe_d = 1'b1;
          data_d = shift_q[31:24];
          shift_d = {shift_q[23:0], 8'h00};
          sent_d = sent_q + 2'd1;
          if (sent_q == 2'(`CFG_WORD_BYTES - 1)) begin
            done_d = 1'b1;
            state_d = por_cfg_pkg::HOST_DONE;
          end
        end
      end
    endcase
  end

  // Registers and link drivers; clocked by core_clk, the same clock as the device
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= por_cfg_pkg::HOST_IDLE;
      word_q <= `CFG_WORD_RESET;
      shift_q <= '0;
      sent_q <= '0;
      select_q <= CTRL_RESET[`HOST_CTRL_SELECT_BIT];
      done_q <= 1'b0;
      por_q <= 1'b0;
      strobe_q <= 1'b0;
      data_q <= 8'h00;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      if (wr_word) begin
        word_q <= wdata;
      end
      if (wr_ctrl) begin
        select_q <= wdata[`HOST_CTRL_SELECT_BIT];
      end
      shift_q <= shift_d;
      sent_q <= sent_d;
      done_q <= done_d;
      por_q <= link.power_on_reset_in;
      strobe_q <= strobe_d;
      data_q <= data_d;
      rdata_q <= rd_strobe ? rd_mux : 32'h0000_0000;
    end
  end

  assign link.reset_config_select = select_q;
  assign link.cfg_wr_strobe = strobe_q;
  assign link.cfg_wr_data = data_q;
  assign rdata = rdata_q;

endmodule : por_cfg_host

/* File: rtl/por_cfg_if.sv */
// Link between the sequencing device and the configuring host
`timescale 1ns/1ps
interface por_cfg_if (
  input logic power_on_reset_in
);
  logic reset_config_select;
  logic cfg_wr_strobe;
  logic [7:0] cfg_wr_data;
  logic hard_reset_out;
  logic soft_reset_out;

  modport device (
    input power_on_reset_in,
    input reset_config_select,
    input cfg_wr_strobe,
    input cfg_wr_data,
    output hard_reset_out,
    output soft_reset_out
  );

  modport host (
    input power_on_reset_in,
    output reset_config_select,
    output cfg_wr_strobe,
    output cfg_wr_data,
    input hard_reset_out,
    input soft_reset_out
  );
endinterface : por_cfg_if

/* File: rtl/por_cfg_pkg.sv */
// Types shared by both ends of the reset configuration link
package por_cfg_pkg;

  typedef enum logic [3:0] {
    SEQ_POR,
    SEQ_HOST_CFG,
    SEQ_CONFIG,
    SEQ_PLL_LOCK,
    SEQ_DLL_LOCK,
    SEQ_HARD_HOLD,
    SEQ_SOFT_LAG,
    SEQ_RUN
  } seq_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_WAIT_POR,
    HOST_SEND,
    HOST_DONE
  } host_state_t;

endpackage : por_cfg_pkg

/* File: rtl/por_cfg_regs.svh */
// Constants for the power-on reset configuration sequencer and its host
`ifndef POR_CFG_REGS_SVH
`define POR_CFG_REGS_SVH

// Sequence lengths, in core clock cycles
`define CFG_CONFIG_CYCLES 1024
`define CFG_PLL_LOCK_CYCLES 800
`define CFG_DLL_LOCK_CYCLES 256
`define CFG_HARD_HOLD_CYCLES 512
`define CFG_SOFT_LAG_CYCLES 3
`define CFG_CNT_W 11

// Reset configuration word layout
`define CFG_WORD_BYTES 4
`define CFG_DLL_BYPASS_BIT 28
`define CFG_CLK_HIGH_LSB 24
`define CFG_CLK_HIGH_W 4
`define CFG_WORD_RESET 32'h0000_0000

// Host controller register map (byte addresses)
`define HOST_ADDR_W 4
`define HOST_REG_WORD 4'h0
`define HOST_REG_CTRL 4'h4
`define HOST_REG_STATUS 4'h8

// Host control bits
`define HOST_CTRL_GO_BIT 0
`define HOST_CTRL_SELECT_BIT 1
`define HOST_CTRL_RESET 32'h0000_0002

// Host status bits
`define HOST_STAT_BUSY_BIT 0
`define HOST_STAT_SENT_BIT 1
`define HOST_STAT_HARD_BIT 2
`define HOST_STAT_SOFT_BIT 3
`define HOST_STAT_POR_BIT 4

`endif
